// [bench/csg_exec_props.sv]
// checker for the compare-skip block
`timescale 1ns/1ns
module csg_exec_props (
    input wire mclk, // clock
    input wire reset, // reset
    input wire [15:0] instr_word, // opcode
    input wire [15:0] next_word, // next word
    input wire [3:0] bank_select_register, // bank
    input wire [7:0] working_register, // w
    input wire [7:0] file_rdata, // file byte
    input wire file_rd_r, // read
    input wire [11:0] file_addr_r, // address
    input wire skip_r, // skip
    input wire nop_cycle_r // no-op
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire tw = next_word[15:11] inside {5'h18, 5'h1d, 5'h1e};
    property p_rd; file_rd_r |=> !file_rd_r; endproperty
    property p_bank; file_rd_r && $past(instr_word[8]) |->
        file_addr_r == {$past(bank_select_register), $past(instr_word[7:0])}; endproperty
    property p_acc; file_rd_r && $past(instr_word[8:7]) == 2'h1 |->
        file_addr_r == {4'hf, $past(instr_word[7:0])}; endproperty
    property p_cmp; file_rd_r |-> ##2 skip_r == (file_rdata > working_register); endproperty
    property p_nop; $rose(skip_r) |=> nop_cycle_r; endproperty
    property p_one; $rose(nop_cycle_r) && !$past(tw, 4) |-> nop_cycle_r[*4] ##1 !nop_cycle_r;
    endproperty
    property p_two; $rose(nop_cycle_r) && $past(tw, 4) |-> nop_cycle_r[*8] ##1 !nop_cycle_r;
    endproperty
    property p_keep; file_rd_r ##2 !skip_r |=> !nop_cycle_r; endproperty
    a_rd: assert property (p_rd) else $error("read too long");
    a_bank: assert property (p_bank) else $error("bad bank address");
    a_acc: assert property (p_acc) else $error("bad access address");
    a_cmp: assert property (p_cmp) else $error("bad compare");
    a_nop: assert property (p_nop) else $error("no discard");
    a_one: assert property (p_one) else $error("bad skip length");
    a_two: assert property (p_two) else $error("bad long skip");
    a_keep: assert property (p_keep) else $error("false skip");
    c_keep: cover property (file_rd_r ##2 !skip_r);
    c_two: cover property ($rose(nop_cycle_r) && $past(tw, 4));
    c_skip: cover property ($rose(skip_r));
endmodule
////////////////////////////////////////
bind csg_exec csg_exec_props chk_u (
    .mclk                 (mclk),
    .reset                (reset),
    .instr_word           (instr_word),
    .next_word            (next_word),
    .bank_select_register (bank_select_register),
    .working_register     (working_register),
    .file_rdata           (file_rdata),
    .file_rd_r            (file_rd_r),
    .file_addr_r          (file_addr_r),
    .skip_r               (skip_r),
    .nop_cycle_r          (nop_cycle_r)
);

// [bench/csg_exec_tb.sv]
// bench for the compare-skip block
`timescale 1ns/1ns
module csg_exec_tb;
    logic mclk = 0, reset = 1, instr_valid = 0, ext_set_en = 0;
    logic [15:0] instr_word = 0, next_word = 0;
    logic [3:0] bank_select_register = 0, en;
    logic [11:0] fsr2_base = 12'h100, ea;
    logic [7:0] working_register = 0, file_rdata = 0;
    wire decode_hit_r, file_rd_r, skip_r, nop_cycle_r, pc_advance_r, busy_r;
    wire [11:0] file_addr_r;
    wire [1:0] qphase_o_r;
    int failures = 0, cmp_count = 0, n, p;
    logic [68:0] rows [6] = '{
        {16'h647f, 16'h0000, 8'h80, 8'h81, 4'h5, 1'h0, 12'h07f, 4'h4},
        {16'h6460, 16'h0000, 8'h55, 8'h55, 4'h5, 1'h1, 12'h060, 4'h0},
        {16'h645f, 16'hc123, 8'h00, 8'hff, 4'h5, 1'h1, 12'h15f, 4'h8},
        {16'h6500, 16'hf000, 8'h01, 8'h02, 4'hf, 1'h0, 12'hf00, 4'h8},
        {16'h6490, 16'he800, 8'hfe, 8'hff, 4'h3, 1'h0, 12'hf90, 4'h8},
        {16'h6533, 16'hc000, 8'h80, 8'h7f, 4'h2, 1'h1, 12'h233, 4'h0}};
    csg_exec dut_u (
        .mclk                 (mclk),
        .reset                (reset),
        .instr_valid          (instr_valid),
        .instr_word           (instr_word),
        .next_word            (next_word),
        .ext_set_en           (ext_set_en),
        .bank_select_register (bank_select_register),
        .fsr2_base            (fsr2_base),
        .working_register     (working_register),
        .file_rdata           (file_rdata),
        .decode_hit_r         (decode_hit_r),
        .file_rd_r            (file_rd_r),
        .file_addr_r          (file_addr_r),
        .skip_r               (skip_r),
        .nop_cycle_r          (nop_cycle_r),
        .pc_advance_r         (pc_advance_r),
        .busy_r               (busy_r),
        .qphase_o_r           (qphase_o_r)
    );
    initial forever #10 mclk = ~mclk;
    task automatic chk(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        failures += int'(seen !== exp);
        if (seen !== exp) $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic run(input logic [68:0] r);
        {instr_word, next_word, working_register, file_rdata} = r[68:21];
        {bank_select_register, ext_set_en, ea, en} = r[20:0];
        instr_valid = 1;
        repeat (12) if (file_rd_r !== 1'h1) @(negedge mclk);
        chk("read", 16'(file_rd_r), 16'h1);
        if (file_rd_r !== 1'h1) tally_and_finish;
        instr_valid = 0;
        chk("addr", 16'(file_addr_r), 16'(ea));
        repeat (2) @(negedge mclk);
        chk("skip", 16'(skip_r), 16'(en != 0));
        chk("owned", 16'({decode_hit_r, busy_r}), 16'h3);
        chk("phase", 16'(qphase_o_r), 16'h2);
        n = 0;
        p = 0;
        repeat (12) @(negedge mclk) begin
            n += int'(nop_cycle_r === 1'h1);
            p += int'(pc_advance_r === 1'h1);
        end
        chk("nops", 16'(n), 16'(en));
        chk("pc_steps", 16'(p), 16'(en[3:2]) + 16'h1);
        chk("idle", 16'({busy_r, skip_r, decode_hit_r}), 16'h0);
        $display("done %h", r[68:53]);
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        chk("reset", 16'({busy_r, skip_r, nop_cycle_r, file_rd_r}), 16'h0);
        $display("reset done");
        reset = 0;
        foreach (rows[i]) run(rows[i]);
        instr_word = 16'h6634;
        instr_valid = 1;
        n = 0;
        repeat (8) @(negedge mclk) n += int'(file_rd_r !== 1'h0);
        chk("foreign", 16'(n), 16'h0);
        $display("foreign done");
        instr_word = rows[4][68:53];
        repeat (8) @(negedge mclk);
        reset = 1;
        instr_valid = 0;
        repeat (2) @(negedge mclk);
        chk("mid_reset", 16'({busy_r, skip_r, nop_cycle_r}), 16'h0);
        $display("mid reset done");
        reset = 0;
        run(rows[0]);
        tally_and_finish;
    end
endmodule

// [src/csg_consts.vh]
// constants for the compare-and-skip-if-greater execution block
`ifndef CSG_CONSTS_VH
`define CSG_CONSTS_VH
`define CSG_OPC_HI_POS     15
`define CSG_OPC_LO_POS     9
`define CSG_OPC_PATTERN    7'h32
`define CSG_ACCESS_POS     8
`define CSG_FADDR_HI       7
`define CSG_ACCESS_SPLIT   8'h80
`define CSG_INDEX_LIMIT    8'h5f
`define CSG_ACC_HI_BANK    4'hf
`define CSG_ACCESS_DEFAULT 1'h1
`define CSG_Q1             2'h0
`define CSG_Q2             2'h1
`define CSG_Q3             2'h2
`define CSG_Q4             2'h3
`define CSG_TWO_WORD_MASK  16'hf800
`define CSG_TWO_WORD_A     16'hc000
`define CSG_TWO_WORD_B     16'he800
`define CSG_TWO_WORD_C     16'hf000
`endif

// [src/csg_exec.v]
// execution unit for the compare-and-skip-if-greater instruction
// Function
// - if the file byte exceeds the working register the fetched next word becomes a no-op.
// - greater-than is an unsigned subtract of working register from file byte, flags untouched.
// - the instruction is recognised by opcode pattern 0110 010a followed by an 8-bit address.
// - access bit zero selects the access bank and ignores the bank select register.
// - access bit one uses the bank select register to pick the general purpose bank.
// - access bit zero with extended set on uses indexed literal offset for addresses up to 5fh.
// - the instruction is one word and one cycle, or two cycles when it skips a one-word instruction.
// - a skip over a two-word instruction costs three cycles and discards both words.
// - executing cycle decodes in q1, reads in q2, processes in q3 and writes nothing in q4.
// - every skip cycle performs no operation in all four quarters.
`timescale 1ns/1ns
module csg_exec (
    input  wire        mclk,            // core clock, 50 mhz
    input  wire        reset,           // sync reset, active high
    input  wire        instr_valid,     // instruction word presented for execution
    input  wire [15:0] instr_word,      // opcode in execution slot
    input  wire [15:0] next_word,       // already fetched following word
    input  wire        ext_set_en,      // extended instruction set enabled
    input  wire [3:0]  bank_select_register, // bank select value
    input  wire [11:0] fsr2_base,       // index base for literal offset mode
    input  wire [7:0]  working_register, // working register value
    input  wire [7:0]  file_rdata,      // data memory read data
    output reg         decode_hit_r,    // this opcode recognised (q2 to q4)
    output reg         file_rd_r,       // data memory read strobe (q2)
    output reg  [11:0] file_addr_r,     // resolved data memory address
    output reg         skip_r,          // compare result: skip taken
    output reg         nop_cycle_r,     // current cycle is a forced no-op
    output reg         pc_advance_r,    // pulse in the q1 after each executing or discarded q4 to advance pc by one word
    output reg         busy_r,          // block owns the pipeline
    output reg  [1:0]  qphase_o_r       // quarter phase
);
`include "csg_consts.vh"
    localparam ST_IDLE = 2'h0;
    localparam ST_EXEC = 2'h1;
    localparam ST_NOP1 = 2'h2;
    localparam ST_NOP2 = 2'h3;

    wire [1:0] qphase;
    reg  [1:0] state_r;
    reg  [1:0] state_nxt;
    reg  [7:0] data_r;
    reg        two_word_r;
    wire       is_op;
    wire       acc_bit;
    wire [7:0] faddr;
    wire [8:0] diff;
    wire       greater;
    wire       succ_two;
    reg  [11:0] addr_nxt;
    wire [15:0] next_class;
    wire        idx_mode;
    wire        acc_low;
    wire        decode_go;
    wire        exec_q2;
    wire        exec_q3;
    wire        exec_q4;
    wire        nop_q4;
    wire        more_nop;

    csg_qphase u_qphase (
        .mclk     (mclk),
        .reset    (reset),
        .qphase_r (qphase)
    );

    ////////////////////////////////////////////////////////////////
    // decode
    assign is_op   = instr_valid &&
        (instr_word[`CSG_OPC_HI_POS:`CSG_OPC_LO_POS] == `CSG_OPC_PATTERN);
    assign acc_bit = instr_word[`CSG_ACCESS_POS];
    assign faddr   = instr_word[`CSG_FADDR_HI:0];
    // unsigned subtract, borrow clear and nonzero means greater
    assign diff    = {1'b0, data_r} - {1'b0, working_register};
    assign greater = !diff[8] && (diff[7:0] != 8'h00);
    assign next_class = next_word & `CSG_TWO_WORD_MASK;
    // successor size from its opcode prefix
    assign succ_two = (next_class == `CSG_TWO_WORD_A) ||
                      (next_class == `CSG_TWO_WORD_B) ||
                      (next_class == `CSG_TWO_WORD_C);
    // literal offset only for the low part of the access window
    assign idx_mode = (acc_bit != `CSG_ACCESS_DEFAULT) && ext_set_en &&
                      (faddr <= `CSG_INDEX_LIMIT);
    assign acc_low  = (faddr < `CSG_ACCESS_SPLIT);

    always @* begin
        if (acc_bit == `CSG_ACCESS_DEFAULT) begin
            addr_nxt = {bank_select_register, faddr};
        end else if (idx_mode) begin
            // index base plus offset, wraps inside the data space
            addr_nxt = fsr2_base + {4'h0, faddr};
        end else if (acc_low) begin
            addr_nxt = {4'h0, faddr};
        end else begin
            // upper access half maps to the top bank
            addr_nxt = {`CSG_ACC_HI_BANK, faddr};
        end
    end

    ////////////////////////////////////////////////////////////////
    // phase strobes of the executing and discarded cycles
    assign decode_go = (state_r == ST_IDLE) && (qphase == `CSG_Q1) && is_op;
    assign exec_q2   = (state_r == ST_EXEC) && (qphase == `CSG_Q2);
    assign exec_q3   = (state_r == ST_EXEC) && (qphase == `CSG_Q3);
    assign exec_q4   = (state_r == ST_EXEC) && (qphase == `CSG_Q4);
    assign nop_q4    = ((state_r == ST_NOP1) || (state_r == ST_NOP2)) &&
                       (qphase == `CSG_Q4);
    assign more_nop  = (state_r == ST_NOP1) && two_word_r;

    ////////////////////////////////////////////////////////////////
    // cycle sequencing
    // one state per instruction cycle, advanced at q4, except idle which is left at q1
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (qphase == `CSG_Q1 && is_op) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (qphase == `CSG_Q4) begin
                    state_nxt = skip_r ? ST_NOP1 : ST_IDLE;
                end
            end
            ST_NOP1: begin
                if (qphase == `CSG_Q4) begin
                    state_nxt = two_word_r ? ST_NOP2 : ST_IDLE;
                end
            end
            ST_NOP2: begin
                if (qphase == `CSG_Q4) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // state and phase echo
    always @(posedge mclk) begin
        if (reset) begin
            state_r    <= ST_IDLE;
            qphase_o_r <= `CSG_Q1;
        end else begin
            state_r    <= state_nxt;
            qphase_o_r <= qphase;
        end
    end

    ////////////////////////////////////////////////////////////////
    // q1 decode: address, read strobe, successor size
    always @(posedge mclk) begin
        if (reset) begin
            decode_hit_r <= 1'b0;
            file_rd_r    <= 1'b0;
            file_addr_r  <= 12'h000;
            two_word_r   <= 1'b0;
        end else begin
            file_rd_r <= decode_go;
            if (decode_go) begin
                decode_hit_r <= 1'b1;
                file_addr_r  <= addr_nxt;
                two_word_r   <= succ_two;
            end else if (exec_q4) begin
                decode_hit_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // q2 read
    always @(posedge mclk) begin
        if (reset) begin
            data_r <= 8'h00;
        end else if (exec_q2) begin
            data_r <= file_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // q3 process, held until the last discarded cycle ends
    always @(posedge mclk) begin
        if (reset) begin
            skip_r <= 1'b0;
        end else if (decode_go) begin
            skip_r <= 1'b0;
        end else if (exec_q3) begin
            skip_r <= greater;
        end else if (nop_q4 && !more_nop) begin
            skip_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // one program counter step per executing or discarded instruction cycle
    always @(posedge mclk) begin
        if (reset) begin
            pc_advance_r <= 1'b0;
        end else begin
            pc_advance_r <= exec_q4 || nop_q4;
        end
    end

    ////////////////////////////////////////////////////////////////
    // discard and ownership, taken from skip_r so q3 and q4 agree
    always @(posedge mclk) begin
        if (reset) begin
            nop_cycle_r <= 1'b0;
            busy_r      <= 1'b0;
        end else if (decode_go) begin
            busy_r <= 1'b1;
        end else if (exec_q4) begin
            nop_cycle_r <= skip_r;
            busy_r      <= skip_r;
        end else if (nop_q4) begin
            nop_cycle_r <= more_nop;
            busy_r      <= more_nop;
        end
    end
endmodule

// [src/csg_qphase.v]
// quarter-phase sequencer of the instruction cycle
`timescale 1ns/1ns
module csg_qphase (
    input  wire       mclk,     // core clock
    input  wire       reset,    // sync reset, active high
    output reg  [1:0] qphase_r  // current quarter phase
);
`include "csg_consts.vh"
    always @(posedge mclk) begin
        if (reset) begin
            qphase_r <= `CSG_Q1;
        end else begin
            qphase_r <= qphase_r + 2'h1;
        end
    end
endmodule
